//--- src/apct_pkg.sv
/*
 * constants, register map and carrier types of the advanced pwm control timer.
 * assumes a 32-bit classic wishbone register bus and one timer kernel clock.
 */
package apct_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_EVGEN = 8'h04;
	localparam logic [7:0] ADR_STAT = 8'h08;
	localparam logic [7:0] ADR_CHCFG = 8'h0C;
	localparam logic [7:0] ADR_CNT = 8'h10;
	localparam logic [7:0] ADR_PSC = 8'h14;
	localparam logic [7:0] ADR_ARR = 8'h18;
	localparam logic [7:0] ADR_REP = 8'h1C;
	localparam logic [7:0] ADR_CCR0 = 8'h20;
	localparam logic [7:0] ADR_CCR1 = 8'h24;
	localparam logic [7:0] ADR_CCR2 = 8'h28;
	localparam logic [7:0] ADR_CCR3 = 8'h2C;
	localparam logic [7:0] ADR_OUTCFG = 8'h30;
	localparam logic [7:0] ADR_CHEN = 8'h34;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int EG_UPD = 0;
	localparam int EG_TRG = 1;
	localparam int ST_UPD = 0;
	localparam int ST_CC0 = 1;
	localparam int ST_TRG = 5;
	localparam int ST_BRK = 6;
	localparam int ST_W = 7;
	localparam int CHEN_N = 4;
	localparam int PIN_TRIG = 4;
	localparam int PIN_BRK = 5;
	localparam logic [15:0] ARR_RST = 16'hFFFF;

	// ------------------------------------------------------------
	// modes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {SMS_OFF, SMS_ENCODER, SMS_RESET, SMS_GATED, SMS_TRIGGER, SMS_EXTCLK} apct_sms_t;
	typedef enum logic [1:0] {TS_PIN, TS_LINK, TS_CH0, TS_HALL} apct_tsel_t;
	typedef enum logic [1:0] {CM_TOGGLE, CM_PWM1, CM_PWM2, CM_CAPTURE} apct_cmode_t;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic dbg_frz;
		logic clr_en;
		logic ccpe;
		apct_tsel_t ts;
		apct_sms_t sms;
		logic arpe;
		logic opm;
		logic center;
		logic down;
		logic cen;
	} apct_ctrl_t;

	typedef struct packed {
		logic fall;
		apct_cmode_t mode;
	} apct_chcfg_t;

	typedef struct packed {
		logic [2:0] idle_n;
		logic [3:0] idle_p;
		logic aoe;
		logic moe;
		logic [7:0] dtg;
	} apct_outcfg_t;

	typedef struct packed {
		logic brk;
		logic trg;
		logic [3:0] cc;
		logic upd;
	} apct_evt_t;

endpackage

//--- src/apct_timer.sv
/*
 * advanced pwm control timer: prescaled 16-bit auto-reload counter, four
 * capture/compare/pwm channels, three complementary pairs with dead time,
 * repetition counter, break, slave/trigger modes, encoder and hall inputs.
 * assumes a classic wishbone master, pins asynchronous to clk_in, and the
 * general purpose timer link on the same clock.
 */
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
module apct_timer #(
	parameter int CW = 16
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// pins
	input wire logic [3:0] ch_in,
	input wire logic trig_in,
	input wire logic brk_in,
	output logic [3:0] oc_out,
	output logic [2:0] ocn_out,
	// system
	input wire logic dbg_halt_in,
	input wire logic link_trg_in,
	output logic link_trgo_out,
	output apct_pkg::apct_evt_t evt_req_out
);

	localparam int NP = 6;
	localparam int CTRL_W = $bits(apct_pkg::apct_ctrl_t);
	localparam int OUT_W = $bits(apct_pkg::apct_outcfg_t);
	localparam int CH_W = $bits(apct_pkg::apct_chcfg_t);

	function automatic logic [31:0] apct_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
		begin
			if (s[b])
				r[b*8 +: 8] = n[b*8 +: 8];
		end
		return r;
	endfunction

	apct_pkg::apct_ctrl_t ctrl_q;
	apct_pkg::apct_outcfg_t out_q;
	apct_pkg::apct_chcfg_t [3:0] chcfg_q;
	logic [6:0] chen_q;
	logic [CW-1:0] cnt_q, psc_q, psc_a_q, psc_cnt_q, arr_q, arr_a_q, arr_use;
	logic [7:0] rep_q, rep_a_q;
	logic [CW-1:0] ccr_q [4];
	logic [CW-1:0] ccr_a_q [4];
	logic [CW-1:0] ccr_use [4];
	logic [apct_pkg::ST_W-1:0] stat_q;
	logic cup_q, ack_q, clr_q, link_prev_q, hall_q, hall_prev_q;
	logic [NP-1:0] s1_q, s2_q, s3_q, pin_q, pin_prev_q, rise, fall;
	logic [3:0] ref_q, refd_q, mprev_q, match, cap_edge, cc_evt;
	logic [7:0] dt_q [3];
	logic acc, wr, trg_lvl, trg_edge, freeze, run, psc_feed, enc, enc_tick, enc_up;
	logic up, tick, wrap, sw_upd, sw_trg, reinit, uev, trg_evt, stop_opm, outs_on;
	logic [31:0] rd_mux, wmask;

	// ------------------------------------------------------------
	// pin synchronisers: a change counts once stages two and three agree
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			pin_q <= '0;
			pin_prev_q <= '0;
			link_prev_q <= 1'b0;
			hall_q <= 1'b0;
			hall_prev_q <= 1'b0;
		end
		else
		begin
			s1_q <= {brk_in, trig_in, ch_in};
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= (pin_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
			pin_prev_q <= pin_q;
			link_prev_q <= link_trg_in;
			hall_q <= ^pin_q[2:0];
			hall_prev_q <= hall_q;
		end
	end

	assign rise = pin_q & ~pin_prev_q;
	assign fall = ~pin_q & pin_prev_q;

	// ------------------------------------------------------------
	// trigger selection and slave control
	// ------------------------------------------------------------
	always_comb
	begin
		case (ctrl_q.ts)
			apct_pkg::TS_LINK:
			begin
				trg_lvl = link_trg_in;
				trg_edge = link_trg_in & ~link_prev_q;
			end
			apct_pkg::TS_CH0:
			begin
				trg_lvl = pin_q[0];
				trg_edge = rise[0];
			end
			apct_pkg::TS_HALL:
			begin
				trg_lvl = hall_q;
				trg_edge = hall_q ^ hall_prev_q;
			end
			default:
			begin
				trg_lvl = pin_q[apct_pkg::PIN_TRIG];
				trg_edge = rise[apct_pkg::PIN_TRIG];
			end
		endcase
	end

	assign acc = wb_cyc_in & wb_stb_in & ~ack_q;
	assign wr = acc & wb_we_in;
	assign sw_upd = wr & (wb_adr_in == apct_pkg::ADR_EVGEN) & wb_sel_in[0] & wb_dat_in[apct_pkg::EG_UPD];
	assign sw_trg = wr & (wb_adr_in == apct_pkg::ADR_EVGEN) & wb_sel_in[0] & wb_dat_in[apct_pkg::EG_TRG];
	assign freeze = ctrl_q.dbg_frz & dbg_halt_in;
	assign run = ctrl_q.cen & ~freeze & ((ctrl_q.sms != apct_pkg::SMS_GATED) | trg_lvl);
	assign psc_feed = (ctrl_q.sms == apct_pkg::SMS_EXTCLK) ? trg_edge : 1'b1;
	assign enc = ctrl_q.sms == apct_pkg::SMS_ENCODER;
	assign enc_tick = rise[0] | fall[0] | rise[1] | fall[1];
	assign enc_up = ((rise[0] | fall[0]) & (pin_q[0] != pin_q[1])) | ((rise[1] | fall[1]) & (pin_q[0] == pin_q[1]));
	assign tick = run & (enc ? enc_tick : psc_feed & (psc_cnt_q == psc_a_q));
	assign up = enc ? enc_up : (ctrl_q.center ? cup_q : ~ctrl_q.down);
	assign arr_use = ctrl_q.arpe ? arr_a_q : arr_q;
	assign wrap = tick & (up ? (cnt_q >= arr_use) : (cnt_q == '0));
	assign reinit = sw_upd | (trg_edge & (ctrl_q.sms == apct_pkg::SMS_RESET));
	assign uev = reinit | (wrap & (rep_q == '0));
	assign stop_opm = ctrl_q.opm & wrap & (rep_q == '0);
	assign trg_evt = sw_trg | (trg_edge & ((ctrl_q.sms == apct_pkg::SMS_RESET) | (ctrl_q.sms == apct_pkg::SMS_GATED)
		| (ctrl_q.sms == apct_pkg::SMS_TRIGGER) | (ctrl_q.sms == apct_pkg::SMS_EXTCLK)));

	// ------------------------------------------------------------
	// counter and prescaler
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			cnt_q <= '0;
			psc_cnt_q <= '0;
			cup_q <= 1'b1;
		end
		else if (wr && wb_adr_in == apct_pkg::ADR_CNT)
			cnt_q <= CW'(apct_merge(32'(cnt_q), wb_dat_in, wb_sel_in));
		else if (reinit)
		begin
			cnt_q <= (ctrl_q.down & ~ctrl_q.center) ? arr_use : '0;
			psc_cnt_q <= '0;
			cup_q <= 1'b1;
		end
		else
		begin
			if (run && psc_feed && !enc)
				psc_cnt_q <= (psc_cnt_q == psc_a_q) ? '0 : psc_cnt_q + 1'b1;
			if (tick)
			begin
				if (ctrl_q.center && !enc)
				begin
					if (cup_q && cnt_q >= arr_use)
					begin
						cup_q <= 1'b0;
						cnt_q <= arr_use - 1'b1;
					end
					else if (!cup_q && cnt_q == '0)
					begin
						cup_q <= 1'b1;
						cnt_q <= CW'(1);
					end
					else
						cnt_q <= cup_q ? cnt_q + 1'b1 : cnt_q - 1'b1;
				end
				else if (up)
					cnt_q <= wrap ? '0 : cnt_q + 1'b1;
				else
					cnt_q <= wrap ? arr_use : cnt_q - 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// shadow registers and repetition counter
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			arr_a_q <= CW'(apct_pkg::ARR_RST);
			psc_a_q <= '0;
			rep_q <= '0;
			for (int i = 0; i < 4; i++)
				ccr_a_q[i] <= '0;
		end
		else if (uev)
		begin
			arr_a_q <= arr_q;
			psc_a_q <= psc_q;
			rep_q <= rep_a_q;
			for (int i = 0; i < 4; i++)
				ccr_a_q[i] <= ccr_q[i];
		end
		else if (wrap)
			rep_q <= rep_q - 1'b1;
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			ctrl_q <= '0;
			out_q <= '0;
			chcfg_q <= '0;
			chen_q <= '0;
			psc_q <= '0;
			arr_q <= CW'(apct_pkg::ARR_RST);
			rep_a_q <= '0;
		end
		else
		begin
			if (wr)
			begin
				case (wb_adr_in)
					apct_pkg::ADR_CTRL: ctrl_q <= apct_pkg::apct_ctrl_t'(CTRL_W'(wmask));
					apct_pkg::ADR_OUTCFG: out_q <= apct_pkg::apct_outcfg_t'(OUT_W'(wmask));
					apct_pkg::ADR_CHCFG: chcfg_q <= (4*CH_W)'(wmask);
					apct_pkg::ADR_CHEN: chen_q <= wmask[6:0];
					apct_pkg::ADR_PSC: psc_q <= CW'(wmask);
					apct_pkg::ADR_ARR: arr_q <= CW'(wmask);
					apct_pkg::ADR_REP: rep_a_q <= wmask[7:0];
					default: ;
				endcase
			end
			if (ctrl_q.sms == apct_pkg::SMS_TRIGGER && trg_edge)
				ctrl_q.cen <= 1'b1;
			else if (stop_opm)
				ctrl_q.cen <= 1'b0;
			// break wins over a software set of the master enable
			if (pin_q[apct_pkg::PIN_BRK])
				out_q.moe <= 1'b0;
			else if (uev && out_q.aoe)
				out_q.moe <= 1'b1;
		end
	end

	always_comb
	begin
		case (wb_adr_in)
			apct_pkg::ADR_CTRL: wmask = apct_merge(32'(ctrl_q), wb_dat_in, wb_sel_in);
			apct_pkg::ADR_OUTCFG: wmask = apct_merge(32'(out_q), wb_dat_in, wb_sel_in);
			apct_pkg::ADR_CHCFG: wmask = apct_merge(32'(chcfg_q), wb_dat_in, wb_sel_in);
			apct_pkg::ADR_CHEN: wmask = apct_merge(32'(chen_q), wb_dat_in, wb_sel_in);
			apct_pkg::ADR_PSC: wmask = apct_merge(32'(psc_q), wb_dat_in, wb_sel_in);
			apct_pkg::ADR_ARR: wmask = apct_merge(32'(arr_q), wb_dat_in, wb_sel_in);
			apct_pkg::ADR_REP: wmask = apct_merge(32'(rep_a_q), wb_dat_in, wb_sel_in);
			default: wmask = wb_dat_in;
		endcase
	end

	// ------------------------------------------------------------
	// channels: capture, compare, reference waveforms
	// ------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			ccr_use[i] = ctrl_q.ccpe ? ccr_a_q[i] : ccr_q[i];
			match[i] = cnt_q == ccr_use[i];
			cap_edge[i] = (chcfg_q[i].mode == apct_pkg::CM_CAPTURE) & (chcfg_q[i].fall ? fall[i] : rise[i]);
			cc_evt[i] = (chcfg_q[i].mode == apct_pkg::CM_CAPTURE) ? cap_edge[i] : match[i] & ~mprev_q[i];
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			for (int i = 0; i < 4; i++)
				ccr_q[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				// a capture edge beats a bus write in the same cycle
				if (cap_edge[i])
					ccr_q[i] <= cnt_q;
				else if (wr && wb_adr_in == apct_pkg::ADR_CCR0 + 8'(4 * i))
					ccr_q[i] <= CW'(apct_merge(32'(ccr_q[i]), wb_dat_in, wb_sel_in));
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			ref_q <= '0;
			mprev_q <= '0;
			clr_q <= 1'b0;
		end
		else
		begin
			mprev_q <= match;
			// cycle-by-cycle limit: pwm-mode ref held low from trigger level until next update; toggle mode ignores it
			if (ctrl_q.clr_en && trg_lvl)
				clr_q <= 1'b1;
			else if (uev)
				clr_q <= 1'b0;
			for (int i = 0; i < 4; i++)
			begin
				case (chcfg_q[i].mode)
					apct_pkg::CM_TOGGLE: ref_q[i] <= cc_evt[i] ? ~ref_q[i] : ref_q[i];
					apct_pkg::CM_PWM1: ref_q[i] <= (cnt_q < ccr_use[i]) & ~clr_q;
					apct_pkg::CM_PWM2: ref_q[i] <= (cnt_q >= ccr_use[i]) & ~clr_q;
					default: ref_q[i] <= 1'b0;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// dead time and output stage
	// ------------------------------------------------------------
	assign outs_on = out_q.moe & ~freeze;

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			refd_q <= '0;
			for (int i = 0; i < 3; i++)
				dt_q[i] <= '0;
		end
		else
		begin
			refd_q <= ref_q;
			for (int i = 0; i < 3; i++)
			begin
				if (ref_q[i] != refd_q[i])
					dt_q[i] <= out_q.dtg;
				else if (dt_q[i] != '0)
					dt_q[i] <= dt_q[i] - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			oc_out <= '0;
			ocn_out <= '0;
		end
		else
		begin
			for (int i = 0; i < 3; i++)
			begin
				if (!outs_on)
					oc_out[i] <= out_q.idle_p[i];
				else if (chen_q[apct_pkg::CHEN_N + i])
					oc_out[i] <= chen_q[i] & ref_q[i] & (ref_q[i] == refd_q[i]) & (dt_q[i] == '0);
				else
					oc_out[i] <= chen_q[i] & ref_q[i];
			end
			// the last channel has no complement, so it never waits for dead time
			oc_out[3] <= outs_on ? chen_q[3] & ref_q[3] : out_q.idle_p[3];
			for (int i = 0; i < 3; i++)
				ocn_out[i] <= outs_on ? chen_q[apct_pkg::CHEN_N + i] & ~ref_q[i] & (ref_q[i] == refd_q[i])
					& (dt_q[i] == '0) : out_q.idle_n[i];
		end
	end

	// ------------------------------------------------------------
	// status flags and event requests
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			stat_q <= '0;
			evt_req_out <= '0;
			link_trgo_out <= 1'b0;
		end
		else
		begin
			// writing zero clears a flag; a new event in that cycle still sets it
			stat_q <= ((wr && wb_adr_in == apct_pkg::ADR_STAT && wb_sel_in[0])
				? stat_q & wb_dat_in[apct_pkg::ST_W-1:0] : stat_q)
				| {rise[apct_pkg::PIN_BRK], trg_evt, cc_evt, uev};
			evt_req_out <= {rise[apct_pkg::PIN_BRK], trg_evt, cc_evt, uev};
			link_trgo_out <= uev;
		end
	end

	// ------------------------------------------------------------
	// wishbone answer: ack one cycle after the request
	// ------------------------------------------------------------
	always_comb
	begin
		case (wb_adr_in)
			apct_pkg::ADR_CTRL: rd_mux = 32'(ctrl_q);
			apct_pkg::ADR_STAT: rd_mux = 32'(stat_q);
			apct_pkg::ADR_CHCFG: rd_mux = 32'(chcfg_q);
			apct_pkg::ADR_CNT: rd_mux = 32'(cnt_q);
			apct_pkg::ADR_PSC: rd_mux = 32'(psc_q);
			apct_pkg::ADR_ARR: rd_mux = 32'(arr_q);
			apct_pkg::ADR_REP: rd_mux = 32'(rep_a_q);
			apct_pkg::ADR_CCR0: rd_mux = 32'(ccr_q[0]);
			apct_pkg::ADR_CCR1: rd_mux = 32'(ccr_q[1]);
			apct_pkg::ADR_CCR2: rd_mux = 32'(ccr_q[2]);
			apct_pkg::ADR_CCR3: rd_mux = 32'(ccr_q[3]);
			apct_pkg::ADR_OUTCFG: rd_mux = 32'(out_q);
			apct_pkg::ADR_CHEN: rd_mux = 32'(chen_q);
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			ack_q <= 1'b0;
			wb_dat_out <= '0;
		end
		else
		begin
			ack_q <= acc;
			if (acc && !wb_we_in)
				wb_dat_out <= rd_mux;
		end
	end

	assign wb_ack_out = ack_q;

endmodule

//--- verification/apct_plant.sv
/*
 * stand-in for the gate drivers and the quadrature encoder.
 * assumes the bench pulses step_in one cycle per encoder step.
 */
`timescale 1ns/10ps
module apct_plant (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// gate side
	input wire logic [3:0] oc_in,
	input wire logic [2:0] ocn_in,
	output logic [7:0] shoot_out,
	output logic [1:0] seen_out,
	// encoder side
	input wire logic step_in,
	output logic [1:0] enc_out
);
	logic [1:0] ph_q;

	// gray phase so a leads b when stepping forward
	assign enc_out = {ph_q[1], ph_q[1] ^ ph_q[0]};

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			ph_q <= 2'h0;
		else if (step_in)
			ph_q <= ph_q + 2'h1;
	end

	// a real bridge would short here, so every cycle with an overlap is counted
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			shoot_out <= 8'h0;
		else if ((oc_in[2:0] & ocn_in) != 3'h0)
			shoot_out <= shoot_out + 8'h1;
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			seen_out <= 2'h0;
		else
			seen_out <= seen_out | {ocn_in[0], oc_in[0]};
	end
endmodule

//--- verification/apct_timer_props.sv
/*
 * port checker for apct_timer.
 * assumes it is bound to the top module and sees its ports only.
 */
`timescale 1ns/10ps
module apct_timer_props (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// bus
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_ack_out,
	// pins
	input wire logic brk_in,
	input wire logic [3:0] oc_out,
	input wire logic [2:0] ocn_out,
	input wire logic link_trgo_out,
	input wire apct_pkg::apct_evt_t evt_req_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);

	// ----
	// sequences
	// ----
	sequence s_req;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	// break pin held long enough to pass the filter
	sequence s_brk_held;
		$rose(brk_in) ##1 brk_in [*3];
	endsequence

	// ----
	// properties
	// ----
	property p_ack_next;
		s_req |=> wb_ack_out;
	endproperty
	property p_ack_one;
		wb_ack_out |=> !wb_ack_out;
	endproperty
	property p_ack_cause;
		wb_ack_out |-> $past(wb_cyc_in && wb_stb_in && !wb_ack_out);
	endproperty
	property p_upd_pulse;
		evt_req_out.upd |=> !evt_req_out.upd;
	endproperty
	property p_trgo_pulse;
		link_trgo_out |=> !link_trgo_out;
	endproperty
	property p_pair_apart;
		(oc_out[2:0] & ocn_out) == 3'h0;
	endproperty
	property p_brk_evt;
		s_brk_held |-> ##[0:5] evt_req_out.brk;
	endproperty
	property p_brk_pulse;
		evt_req_out.brk |=> !evt_req_out.brk;
	endproperty
	property p_reset_quiet;
		$rose(rst_b_in) |-> (oc_out == 4'h0) && (ocn_out == 3'h0) && !wb_ack_out;
	endproperty

	a_ack_next: assert property (p_ack_next) else $error("no ack after request");
	a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	a_upd_pulse: assert property (p_upd_pulse) else $error("update request too long");
	a_trgo_pulse: assert property (p_trgo_pulse) else $error("link trigger too long");
	a_pair_apart: assert property (p_pair_apart) else $error("pair outputs both active");
	a_brk_evt: assert property (p_brk_evt) else $error("break request missing");
	a_brk_pulse: assert property (p_brk_pulse) else $error("break request too long");
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
endmodule

//--- verification/tb.sv
/*
 * self-checking bench for apct_timer over wishbone, with plant model.
 * assumes the checker file is compiled before this one.
 */
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
	logic clk_in, rst_b_in, cyc, stb, we, ch2, brk, dbg, link, step, trg;
	logic [7:0] adr;
	logic [31:0] dat, q, a, rdat;
	logic [3:0] oc;
	logic [2:0] ocn;
	logic [7:0] shoot;
	logic [1:0] seen, enc;
	logic ack, trgo;
	apct_pkg::apct_evt_t evt;
	int mismatches = 0, samples_checked = 0;
	int tick = 0, upd_at = 0, upd_gap = 0, upd_n = 0, trg_n = 0, brk_n = 0, cc0_n = 0, cc2_n = 0, trgo_n = 0;
	int c, u;
	logic [31:0] cfg [4] = '{32'h1, 32'h3, 32'h5, 32'h1};
	logic [31:0] psc [4] = '{32'h1, 32'h1, 32'h1, 32'h0};
	logic [31:0] rep [4] = '{32'h0, 32'h0, 32'h0, 32'h2};
	int gap [4] = '{20, 20, 18, 30};

	apct_timer #(.CW(16)) i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(dat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .ch_in({1'b0, ch2, enc}), .trig_in(trg), .brk_in(brk), .oc_out(oc),
		.ocn_out(ocn), .dbg_halt_in(dbg), .link_trg_in(link), .link_trgo_out(trgo), .evt_req_out(evt));
	apct_plant i_plant (.clk_in(clk_in), .rst_b_in(rst_b_in), .oc_in(oc), .ocn_in(ocn),
		.shoot_out(shoot), .seen_out(seen), .step_in(step), .enc_out(enc));

	initial
	begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	always @(posedge clk_in)
	begin
		tick++;
		if (evt.upd === 1'b1)
		begin
			upd_gap = tick - upd_at;
			upd_at = tick;
			upd_n++;
		end
		trg_n += int'(evt.trg === 1'b1);
		brk_n += int'(evt.brk === 1'b1);
		cc0_n += int'(evt.cc[0] === 1'b1);
		cc2_n += int'(evt.cc[2] === 1'b1);
		trgo_n += int'(trgo === 1'b1);
	end

	// ----
	// bus and helpers
	// ----
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ad;
		dat <= d;
		do
		begin
			@(posedge clk_in);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1)
			mismatches++;
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		bus(1'b1, ad, d);
	endtask
	task automatic rd(input logic [7:0] ad);
		bus(1'b0, ad, 32'h0);
	endtask
	task automatic wait_upd(input int k);
		int s, n;
		s = upd_n;
		n = 0;
		while (upd_n < s + k && n < 2000)
		begin
			@(posedge clk_in);
			n++;
		end
		if (upd_n < s + k)
			mismatches++;
	endtask
	task automatic trg_pulse();
		trg <= 1'b1;
		repeat (6) @(posedge clk_in);
		trg <= 1'b0;
		repeat (6) @(posedge clk_in);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		repeat (30000) @(posedge clk_in);
		mismatches++;
		stop_test();
	end

	// ----
	// tests
	// ----
	initial
	begin
		{rst_b_in, cyc, stb, we, ch2, brk, dbg, link, step, trg, adr, dat} = '0;
		repeat (16) @(posedge clk_in);
		rst_b_in <= 1'b1;
		rd(apct_pkg::ADR_ARR);
		`CHK("arr reset", 32'h0000FFFF, q)
		wr(8'h3C, 32'hFFFFFFFF);
		rd(8'h3C);
		`CHK("unmapped", 32'h0, q)
		for (int i = 0; i < 4; i++)
		begin
			wr(apct_pkg::ADR_CTRL, 32'h0);
			wr(apct_pkg::ADR_ARR, 32'h9);
			wr(apct_pkg::ADR_PSC, psc[i]);
			wr(apct_pkg::ADR_REP, rep[i]);
			wr(apct_pkg::ADR_EVGEN, 32'h1);
			wr(apct_pkg::ADR_CTRL, cfg[i]);
			wait_upd(3);
			`CHK("update gap", gap[i], upd_gap)
		end
		wr(apct_pkg::ADR_CTRL, 32'h0);
		wr(apct_pkg::ADR_ARR, 32'h13);
		wr(apct_pkg::ADR_PSC, 32'h0);
		wr(apct_pkg::ADR_REP, 32'h0);
		wr(apct_pkg::ADR_EVGEN, 32'h1);
		wr(apct_pkg::ADR_CHCFG, 32'h1);
		wr(apct_pkg::ADR_CCR0, 32'hA);
		wr(apct_pkg::ADR_OUTCFG, 32'h103);
		wr(apct_pkg::ADR_CHEN, 32'h11);
		c = cc0_n;
		wr(apct_pkg::ADR_CTRL, 32'h1);
		wait_upd(4);
		`CHK("pair toggled", 2'h3, seen)
		`CHK("overlaps", 8'h0, shoot)
		`CHK("compare events", 1'b1, cc0_n > c + 2)
		@(posedge clk_in);
		brk <= 1'b1;
		repeat (12) @(posedge clk_in);
		`CHK("break outputs", 7'h0, {oc, ocn})
		`CHK("break events", 1, brk_n)
		brk <= 1'b0;
		rd(apct_pkg::ADR_OUTCFG);
		`CHK("moe after break", 1'b0, q[8])
		rd(apct_pkg::ADR_STAT);
		`CHK("break flag", 1'b1, q[apct_pkg::ST_BRK])
		wr(apct_pkg::ADR_STAT, 32'h0);
		rd(apct_pkg::ADR_STAT);
		`CHK("break flag clear", 1'b0, q[apct_pkg::ST_BRK])
		wr(apct_pkg::ADR_OUTCFG, 32'h103);
		wr(apct_pkg::ADR_CTRL, 32'h1001);
		dbg <= 1'b1;
		repeat (4) @(posedge clk_in);
		rd(apct_pkg::ADR_CNT);
		a = q;
		rd(apct_pkg::ADR_CNT);
		`CHK("frozen count", a, q)
		`CHK("frozen outputs", 7'h0, {oc, ocn})
		dbg <= 1'b0;
		rd(apct_pkg::ADR_CNT);
		`CHK("count resumes", 1'b1, q !== a)
		wr(apct_pkg::ADR_CTRL, 32'h0);
		wr(apct_pkg::ADR_CNT, 32'h1234);
		wr(apct_pkg::ADR_CHCFG, 32'hC0);
		c = cc2_n;
		ch2 <= 1'b1;
		repeat (10) @(posedge clk_in);
		`CHK("capture events", 1, cc2_n - c)
		rd(apct_pkg::ADR_CCR2);
		`CHK("captured count", 32'h1234, q)
		wr(apct_pkg::ADR_ARR, 32'hFFFF);
		wr(apct_pkg::ADR_CNT, 32'h100);
		wr(apct_pkg::ADR_CTRL, 32'h141);
		c = trg_n;
		u = upd_n;
		link <= 1'b1;
		repeat (3) @(posedge clk_in);
		link <= 1'b0;
		repeat (3) @(posedge clk_in);
		`CHK("link trigger", 1, trg_n - c)
		`CHK("reinit update", 1, upd_n - u)
		rd(apct_pkg::ADR_CNT);
		`CHK("reinit count", 1'b1, q < 32'h10)
		wr(apct_pkg::ADR_CTRL, 32'h21);
		wr(apct_pkg::ADR_CNT, 32'h0);
		repeat (8)
		begin
			@(posedge clk_in);
			step <= 1'b1;
			@(posedge clk_in);
			step <= 1'b0;
			repeat (8) @(posedge clk_in);
		end
		rd(apct_pkg::ADR_CNT);
		`CHK("encoder count", 32'h8, q)
		wr(apct_pkg::ADR_CTRL, 32'h80);
		wr(apct_pkg::ADR_CNT, 32'h0);
		trg_pulse();
		rd(apct_pkg::ADR_CTRL);
		`CHK("trigger start", 1'b1, q[0])
		wr(apct_pkg::ADR_CTRL, 32'hA1);
		wr(apct_pkg::ADR_CNT, 32'h0);
		repeat (5) trg_pulse();
		rd(apct_pkg::ADR_CNT);
		`CHK("external clock", 32'h5, q)
		wr(apct_pkg::ADR_ARR, 32'h9);
		wr(apct_pkg::ADR_CNT, 32'h0);
		wr(apct_pkg::ADR_CTRL, 32'h9);
		repeat (30) @(posedge clk_in);
		rd(apct_pkg::ADR_CTRL);
		`CHK("one pulse stop", 1'b0, q[0])
		rd(apct_pkg::ADR_CNT);
		`CHK("one pulse rest", 32'h0, q)
		`CHK("link chaining", upd_n, trgo_n)
		stop_test();
	end
endmodule

bind apct_timer apct_timer_props i_props (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in),
	.wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .brk_in(brk_in), .oc_out(oc_out), .ocn_out(ocn_out),
	.link_trgo_out(link_trgo_out), .evt_req_out(evt_req_out));
